// File: hdl/qdec_pkg.sv
// Constants shared by the two-phase event counter.
// Assumes a single system clock; all pins arrive asynchronously.
package qdec_pkg;

  // Channel layout: index 0..2 serves counter channels 2..4
  localparam int CH_N = 3;
  localparam int CH_Z_IDX = 1;
  localparam int CH_NORMAL_IDX = 0;
  localparam int CH_X4_IDX = 2;

  // Counter geometry
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  // Reset values
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;

  // Synchroniser depth ahead of edge detection
  localparam int SYNC_STAGES = 2;

endpackage

// File: hdl/quadrature_event_counter.sv
// Three-channel 16-bit two-phase (quadrature) event counter with Z-phase clear.
// Assumes software bits arrive as plain ports on sys_clk_i; phase and Z pins are asynchronous.
// Phase changes must sit at least one clock apart to be resolved.
// Every output is taken straight from a register.
`timescale 1ns/100ps

module quadrature_event_counter (
  input wire logic sys_clk_i,                 // System clock, 25 MHz
  input wire logic nrst_i,                    // Asynchronous reset, active low
  input wire logic [2:0] phase_a_input_pin_i, // Output-pin phase per channel 2..4
  input wire logic [2:0] phase_b_input_pin_i, // Input-pin phase per channel 2..4
  input wire logic ext_irq2_pin_i,            // Z phase for channel 3
  input wire logic [2:0] channel_run_bit_i,   // Run bit per channel
  input wire logic [2:0] free_run_i,          // Free-running select per channel
  input wire logic ch3_x4_sel_i,              // Channel 3 decoding: 1 = times four
  input wire logic z_clear_enable_bit_i,      // Z-phase clear enable
  input wire logic edge_polarity_bit_i,       // Z edge: 1 = rising, 0 = falling
  input wire logic [2:0] cnt_wr_i,            // Counter register write strobe
  input wire logic [15:0] cnt_wr_data_i,      // Counter register write data
  output logic [47:0] count_o,                // Current counts, channel 2 in low word
  output logic [2:0] irq_o                    // Interrupt request pulse per channel
);

  genvar g;

  // Z-phase synchroniser and edge detector, shared by channel 3 only
  logic [qdec_pkg::SYNC_STAGES-1:0] z_sync_r;
  logic z_prev_r;
  logic z_now;
  logic z_rise;
  logic z_fall;
  logic z_edge;

  // Two flops ahead of any logic that reads the pin
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      z_sync_r <= '0;
    end else begin
      z_sync_r <= {z_sync_r[0], ext_irq2_pin_i};
    end
  end

  assign z_now = z_sync_r[qdec_pkg::SYNC_STAGES-1];

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      z_prev_r <= 1'b0;
    end else begin
      z_prev_r <= z_now;
    end
  end

  assign z_rise = z_now & ~z_prev_r;
  assign z_fall = ~z_now & z_prev_r;

  // Active edge picked by polarity
  always_comb begin
    if (edge_polarity_bit_i) begin
      z_edge = z_rise;
    end else begin
      z_edge = z_fall;
    end
  end

  generate
    for (g = 0; g < qdec_pkg::CH_N; g = g + 1) begin : g_ch
      logic [qdec_pkg::SYNC_STAGES-1:0] a_sync_r;
      logic [qdec_pkg::SYNC_STAGES-1:0] b_sync_r;
      logic a_prev_r;
      logic b_prev_r;
      logic [15:0] cnt_r;
      logic [15:0] cnt_nxt;
      logic [15:0] reload_r;
      logic [15:0] reload_nxt;
      logic seen_r;
      logic seen_nxt;
      logic zpend_r;
      logic zpend_nxt;
      logic irq_r;
      logic irq_nxt;
      logic dbl_r;
      logic dbl_nxt;
      logic x4_mode;
      logic a_now;
      logic b_now;
      logic [3:0] trans;
      logic x4_up;
      logic x4_dn;
      logic b_rise;
      logic b_fall;
      logic nrm_up;
      logic nrm_dn;
      logic ev_up;
      logic ev_dn;
      logic cnt_ev;
      logic ovf;
      logic udf;
      logic wrap;
      logic z_active;
      logic z_fire;
      logic wr_both;

      // Phase pins are both inputs here; two flops each before decoding
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          a_sync_r <= '0;
        end else begin
          a_sync_r <= {a_sync_r[0], phase_a_input_pin_i[g]};
        end
      end

      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          b_sync_r <= '0;
        end else begin
          b_sync_r <= {b_sync_r[0], phase_b_input_pin_i[g]};
        end
      end

      // Last synchronised levels, for edge detection
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          a_prev_r <= 1'b0;
          b_prev_r <= 1'b0;
        end else begin
          a_prev_r <= a_now;
          b_prev_r <= b_now;
        end
      end

      assign a_now = a_sync_r[qdec_pkg::SYNC_STAGES-1];
      assign b_now = b_sync_r[qdec_pkg::SYNC_STAGES-1];

      // Previous and present levels: A prev, B prev, A now, B now
      assign trans = {a_prev_r, b_prev_r, a_now, b_now};

      // Decoding fixed on channels 2 and 4, selectable on channel 3
      if (g == qdec_pkg::CH_Z_IDX) begin : g_sel
        assign x4_mode = ch3_x4_sel_i;
      end else if (g == qdec_pkg::CH_X4_IDX) begin : g_x4
        assign x4_mode = 1'b1;
      end else begin : g_norm
        assign x4_mode = 1'b0;
      end

      // Times-four table: forward runs AB 00, 10, 11, 01; both phases moving is ignored
      always_comb begin
        x4_up = 1'b0;
        x4_dn = 1'b0;
        case (trans)
          4'h2: begin
            x4_up = 1'b1;
          end
          4'hB: begin
            x4_up = 1'b1;
          end
          4'hD: begin
            x4_up = 1'b1;
          end
          4'h4: begin
            x4_up = 1'b1;
          end
          4'h8: begin
            x4_dn = 1'b1;
          end
          4'hE: begin
            x4_dn = 1'b1;
          end
          4'h7: begin
            x4_dn = 1'b1;
          end
          4'h1: begin
            x4_dn = 1'b1;
          end
          default: begin
            x4_up = 1'b0;
            x4_dn = 1'b0;
          end
        endcase
      end

      // Normal decoding counts only B edges while A is high
      assign b_rise = b_now & ~b_prev_r;
      assign b_fall = ~b_now & b_prev_r;
      assign nrm_up = b_rise & a_now;
      assign nrm_dn = b_fall & a_now;

      // Direction of this cycle's step, if any
      always_comb begin
        if (x4_mode) begin
          ev_up = x4_up;
          ev_dn = x4_dn;
        end else begin
          ev_up = nrm_up;
          ev_dn = nrm_dn;
        end
      end

      // Count and write qualification for this channel
      always_comb begin
        cnt_ev = channel_run_bit_i[g] & (ev_up | ev_dn);
        wr_both = cnt_wr_i[g] & (~channel_run_bit_i[g] | ~seen_r);
      end

      // Wrap only on a step past the end of the range
      always_comb begin
        ovf = ev_up & (cnt_r == qdec_pkg::CNT_MAX);
        udf = ev_dn & (cnt_r == qdec_pkg::CNT_ZERO);
        wrap = ovf | udf;
      end

      // Z clear only on channel 3 in free-run, x4, enabled
      if (g == qdec_pkg::CH_Z_IDX) begin : g_z
        assign z_active = channel_run_bit_i[g] & z_clear_enable_bit_i &
                          free_run_i[g] & x4_mode;
      end else begin : g_noz
        assign z_active = 1'b0;
      end
      assign z_fire = cnt_ev & zpend_r & z_active;

      // First count-source pulse since start
      always_comb begin
        seen_nxt = seen_r;
        if (!channel_run_bit_i[g]) begin
          seen_nxt = 1'b0;
        end else if (cnt_ev) begin
          seen_nxt = 1'b1;
        end
      end

      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          seen_r <= 1'b0;
        end else begin
          seen_r <= seen_nxt;
        end
      end

      // Reload register takes every write
      always_comb begin
        reload_nxt = reload_r;
        if (cnt_wr_i[g]) begin
          reload_nxt = cnt_wr_data_i;
        end
      end

      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          reload_r <= qdec_pkg::RELOAD_RST;
        end else begin
          reload_r <= reload_nxt;
        end
      end

      // Counter next value: write, Z clear, reload, then plain step
      always_comb begin
        cnt_nxt = cnt_r;
        if (wr_both) begin
          cnt_nxt = cnt_wr_data_i;
        end else if (cnt_ev) begin
          if (z_fire) begin
            cnt_nxt = qdec_pkg::CNT_ZERO;
          end else if (wrap && !free_run_i[g]) begin
            cnt_nxt = reload_r;
          end else if (ev_up) begin
            cnt_nxt = cnt_r + qdec_pkg::CNT_ONE;
          end else begin
            cnt_nxt = cnt_r - qdec_pkg::CNT_ONE;
          end
        end
      end

      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          cnt_r <= qdec_pkg::CNT_RST;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end

      // Pending Z edge; a new edge in the consuming cycle stays pending
      always_comb begin
        zpend_nxt = zpend_r;
        if (!z_active) begin
          zpend_nxt = 1'b0;
        end else if (z_edge) begin
          zpend_nxt = 1'b1;
        end else if (z_fire) begin
          zpend_nxt = 1'b0;
        end
      end

      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          zpend_r <= 1'b0;
        end else begin
          zpend_r <= zpend_nxt;
        end
      end

      // Interrupt pulse; a Z clear coinciding with a wrap gives a second one
      always_comb begin
        irq_nxt = (cnt_ev & (wrap | z_fire)) | dbl_r;
        dbl_nxt = cnt_ev & z_fire & wrap;
      end

      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          irq_r <= 1'b0;
        end else begin
          irq_r <= irq_nxt;
        end
      end

      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          dbl_r <= 1'b0;
        end else begin
          dbl_r <= dbl_nxt;
        end
      end

      assign count_o[g*qdec_pkg::CNT_W +: qdec_pkg::CNT_W] = cnt_r;
      assign irq_o[g] = irq_r;
    end
  endgenerate

endmodule

// File: sim/qdec_enc.sv
// Encoder model: one quadrature step per request on each channel.
// Assumes requests come well spaced; the bench drives Z itself.
`timescale 1ns/100ps
module qdec_enc (
  input wire logic sys_clk_i, // Clock
  input wire logic [2:0] fwd_i, // Step forward
  input wire logic [2:0] rev_i, // Step backward
  output logic [2:0] a_o, // Output-pin phase
  output logic [2:0] b_o // Input-pin phase
);
  logic [1:0] pos [3] = '{2'h0, 2'h0, 2'h0};
  always @(posedge sys_clk_i) begin
    foreach (pos[i]) pos[i] <= pos[i] + 2'(fwd_i[i]) - 2'(rev_i[i]);
  end
  // A,B = 00,10,11,01 going forward: B rises while A is high
  always_comb begin
    foreach (pos[i]) begin
      a_o[i] = pos[i][1] ^ pos[i][0];
      b_o[i] = pos[i][1];
    end
  end
endmodule

// File: sim/quadrature_event_counter_chk.sv
// Port-level assertions for the quadrature event counter.
// Assumes one clock domain; bound to every counter instance.
`timescale 1ns/100ps
module quadrature_event_counter_chk (
  input wire logic sys_clk_i, // Clock
  input wire logic nrst_i, // Reset
  input wire logic [2:0] channel_run_bit_i, // Run
  input wire logic [2:0] free_run_i, // Free run
  input wire logic [2:0] cnt_wr_i, // Write
  input wire logic [15:0] cnt_wr_data_i, // Data
  input wire logic [47:0] count_o, // Counts
  input wire logic [2:0] irq_o // Requests
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_top4;
    $past(count_o[47:32]) == 16'hFFFF && !$past(cnt_wr_i[2]);
  endsequence
  a_stop_hold: assert property (channel_run_bit_i == 3'h0 && cnt_wr_i == 3'h0
    |=> $stable(count_o) && irq_o == 3'h0) else $error("moved while stopped");
  a_write_idle: assert property (cnt_wr_i[0] && !channel_run_bit_i[0]
    |=> count_o[15:0] == $past(cnt_wr_data_i)) else $error("write lost");
  a_irq_cause2: assert property (irq_o[0]
    |-> $past(count_o[15:0]) inside {16'hFFFF, 16'h0000}) else $error("stray request");
  a_irq_cause4: assert property (irq_o[2]
    |-> $past(count_o[47:32]) inside {16'hFFFF, 16'h0000}) else $error("stray request");
  a_ovf_irq: assert property (s_top4 ##0 count_o[47:32] < 16'hFFFE |-> irq_o[2])
    else $error("missing request");
  a_free_wrap: assert property (s_top4 ##0 irq_o[2] && $past(free_run_i[2])
    |-> count_o[47:32] == 16'h0000) else $error("free run reloaded");
  a_step_ch2: assert property (!irq_o[0] && !$past(cnt_wr_i[0])
    |-> 16'(count_o[15:0] - $past(count_o[15:0])) inside {16'h0000, 16'h0001, 16'hFFFF})
    else $error("step too large");
  a_step_ch4: assert property (!irq_o[2] && !$past(cnt_wr_i[2])
    |-> 16'(count_o[47:32] - $past(count_o[47:32])) inside {16'h0000, 16'h0001, 16'hFFFF})
    else $error("step too large");
endmodule
bind quadrature_event_counter quadrature_event_counter_chk chk_u (.*);

// File: sim/quadrature_event_counter_tb.sv
// Self-checking bench for the quadrature event counter.
// Encoder model drives the phases; the bench drives software bits and Z.
`timescale 1ns/100ps
module quadrature_event_counter_tb;
  typedef struct {int ch; int st; logic x4; logic fr; logic [15:0] ini; logic [15:0] ex;
    int ni;} row_s;
  logic sys_clk_i = 1'b0, nrst_i = 1'b0, z = 1'b0, zen = 1'b0, edge_polarity_bit = 1'b1, x4 = 1'b0;
  logic [2:0] run = 3'h0, fr = 3'h0, wr = 3'h0, fwd = 3'h0, rev = 3'h0, a, b, irq;
  logic [15:0] wd = 16'h0000;
  logic [47:0] cnt;
  int err_total = 0, n_tests = 0, nirq = 0, base = 0;
  row_s rows [6] = '{'{0, 8, 1, 0, 16'h0005, 16'h0007, 0}, '{0, -4, 0, 0, 16'h0000, 16'h0000, 1},
    '{2, 2, 0, 0, 16'hFFFE, 16'hFFFE, 1}, '{2, 1, 0, 1, 16'hFFFF, 16'h0000, 1},
    '{1, -3, 1, 1, 16'h0001, 16'hFFFE, 1}, '{1, 4, 0, 0, 16'h0010, 16'h0011, 0}};
  always #20 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (irq != 3'h0) nirq <= nirq + 1;
  qdec_enc enc_u (.sys_clk_i, .fwd_i(fwd), .rev_i(rev), .a_o(a), .b_o(b));
  quadrature_event_counter dut_u (.sys_clk_i, .nrst_i, .phase_a_input_pin_i(a),
    .phase_b_input_pin_i(b), .ext_irq2_pin_i(z), .channel_run_bit_i(run), .free_run_i(fr),
    .ch3_x4_sel_i(x4), .z_clear_enable_bit_i(zen), .edge_polarity_bit_i(edge_polarity_bit),
    .cnt_wr_i(wr), .cnt_wr_data_i(wd), .count_o(cnt), .irq_o(irq));
  task automatic clk(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic step(input int ch, input int n);
    repeat (n < 0 ? -n : n) begin
      fwd[ch] <= (n > 0);
      rev[ch] <= (n < 0);
      clk(1);
      fwd <= 3'h0;
      rev <= 3'h0;
      clk(6);
    end
  endtask
  task automatic put(input int ch, input logic [15:0] v);
    wr[ch] <= 1'b1;
    wd <= v;
    clk(1);
    wr <= 3'h0;
    clk(1);
  endtask
  task automatic chk(input int ch, input logic [15:0] e, input int ni);
    n_tests++;
    if (cnt[16*ch +: 16] !== e || nirq - base != ni) begin
      err_total++;
      $display("CHECK FAILED at %0t: count %h", $time, cnt[16*ch +: 16]);
    end
    $display("test %0d done", n_tests);
  endtask
  task automatic summarize;
    $display("tests %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk(4);
    nrst_i <= 1'b1;
    clk(1);
    foreach (rows[i]) begin
      x4 <= rows[i].x4;
      fr <= {3{rows[i].fr}};
      put(rows[i].ch, rows[i].ini);
      base = nirq;
      run[rows[i].ch] <= 1'b1;
      step(rows[i].ch, rows[i].st);
      run <= 3'h0;
      clk(1);
      chk(rows[i].ch, rows[i].ex, rows[i].ni);
    end
    put(0, 16'h0003);
    base = nirq;
    run[0] <= 1'b1;
    step(0, 4);
    put(0, 16'h0009);
    chk(0, 16'h0004, 0);
    run <= 3'h0;
    step(0, 4);
    chk(0, 16'h0004, 0);
    x4 <= 1'b1;
    fr <= 3'h7;
    zen <= 1'b1;
    for (int p = 1; p >= 0; p--) begin
      edge_polarity_bit <= 1'(p);
      z <= !1'(p);
      put(1, 16'h0000);
      base = nirq;
      run[1] <= 1'b1;
      step(1, 3);
      z <= 1'(p);
      clk(3);
      z <= !1'(p);
      step(1, 1);
      run <= 3'h0;
      clk(1);
      chk(1, 16'h0000, 1);
    end
    put(1, 16'h0000);
    base = nirq;
    run[1] <= 1'b1;
    z <= 1'b0;
    clk(3);
    z <= 1'b1;
    step(1, -1);
    run <= 3'h0;
    clk(1);
    chk(1, 16'h0000, 2);
    summarize();
  end
endmodule
